// ### hdl/ihp_pkg.sv
package ihp_pkg;
    localparam int          WORD_W     = 22;
    localparam int          HIGH_W     = 6;
    localparam int          HOLD_W     = 16;
    localparam int          IADDR_W    = 10;
    localparam logic [2:0]  ADR_DLOW   = 3'h0;
    localparam logic [2:0]  ADR_DMID   = 3'h1;
    localparam logic [2:0]  ADR_DHIGH  = 3'h2;
    localparam logic [2:0]  ADR_CHEN   = 3'h3;
    localparam logic [2:0]  ADR_PSYNC  = 3'h4;
    localparam logic [2:0]  ADR_SSYNC  = 3'h5;
    localparam logic [2:0]  ADR_IALOW  = 3'h6;
    localparam logic [2:0]  ADR_ACC    = 3'h7;
    localparam int          ACC_AINC   = 7;
    localparam int          ACC_RSV    = 6;
    localparam int          ACC_INS_HI = 5;
    localparam int          ACC_INS_LO = 2;
    localparam int          CH_EN_A    = 0;
    localparam int          CH_ST_A    = 1;
    localparam int          CH_EN_B    = 2;
    localparam int          CH_ST_B    = 3;
    localparam int          PS_PIN     = 0;
    localparam int          PS_EDGE    = 4;
    localparam int          PS_FIRST   = 5;
    localparam int          SS_SOFT    = 0;
    localparam int          SS_BLK_LO  = 4;
    localparam int          SS_BLK_HI  = 6;
    localparam logic [7:0]  ACC_HOST_MASK = 8'hbc;
    localparam logic        MODE_SEP   = 1'b0;
    localparam logic        MODE_DS    = 1'b1;
    localparam int          CLK_DIV    = 2;
endpackage

// ### hdl/ihp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ihp_if;
    logic       mode;
    logic       cs_n;
    logic       rd_ds_n;
    logic       wr_rw;
    logic [2:0] addr;
    logic [7:0] host_d;
    logic       host_oe_n;
    logic [7:0] dev_d;
    logic       dev_oe_n;
    logic       ack;
    logic [7:0] d_bus;
    // wired bus level, pulled high when nobody drives
    assign d_bus = !dev_oe_n ? dev_d : (!host_oe_n ? host_d : 8'hff);
    modport dev (input mode, cs_n, rd_ds_n, wr_rw, addr, d_bus,
                 output dev_d, dev_oe_n, ack);
    modport host (input d_bus, ack,
                  output mode, cs_n, rd_ds_n, wr_rw, addr, host_d, host_oe_n);
endinterface
`default_nettype wire

// ### hdl/ihp_device.sv
`timescale 1ns/1ps
`default_nettype none
module ihp_device
    import ihp_pkg::*;
#(
    parameter int DIV = CLK_DIV
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_n,
    // host bus
    ihp_if.dev                      bus,
    // chip strap, sync pin and soft sync holdoff count
    input  wire logic [1:0]         i_device_select_identifier,
    input  wire logic               i_sync_pin,
    input  wire logic [HOLD_W-1:0]  i_holdoff,
    // internal register access
    output logic                    o_int_wr,
    output logic                    o_int_rd,
    output logic [IADDR_W-1:0]      o_int_addr,
    output logic [WORD_W-1:0]       o_int_wdata,
    input  wire logic [WORD_W-1:0]  i_int_rdata,
    input  wire logic               i_int_done,
    // channel control
    output logic [1:0]              o_chan_active,
    output logic [2:0]              o_blk_sync
);

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_DONE} ihp_dst_t;

    typedef struct packed {
        ihp_dst_t              st;
        logic                  rd;
        logic                  wait_int;
        logic                  drv;
        logic [2:0]            sel;
        logic [7:0]            dout;
        logic [7:0]            acc;
        logic [7:0]            ialow;
        logic [WORD_W-1:0]     data;
        logic [1:0]            en;
        logic [1:0]            act;
        logic                  ps_pin;
        logic                  ps_edge;
        logic                  ps_first;
        logic [2:0]            ss_blk;
        logic [HOLD_W-1:0]     hold;
        logic                  hold_run;
        logic [7:0]            div;
        logic                  sync_m;
        logic                  sync_s;
        logic                  sync_d;
        logic                  int_wr;
        logic                  int_rd;
        logic [IADDR_W-1:0]    int_addr;
        logic [WORD_W-1:0]     int_wdata;
        logic [2:0]            blk;
    } ihp_dstate_t;

    ihp_dstate_t q;
    ihp_dstate_t next_q;

    logic       strobe;
    logic       rd_req;
    logic       sel_me;
    logic [3:0] ins;
    logic       div_en;
    logic       pin_evt;
    logic       soft_evt;
    logic       sync_evt;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb begin
        if (bus.mode == MODE_DS) begin
            strobe = !bus.cs_n && !bus.rd_ds_n;
            rd_req = bus.wr_rw;
        end else begin
            strobe = !bus.cs_n && (!bus.rd_ds_n || !bus.wr_rw);
            rd_req = !bus.rd_ds_n;
        end
    end

    assign ins    = q.acc[ACC_INS_HI:ACC_INS_LO];
    assign sel_me = !ins[3]
                 || (ins[3:1] == 3'b100 && ins[0] == i_device_select_identifier[0])
                 || (ins[3:2] == 2'b11 && ins[1:0] == i_device_select_identifier);

    function automatic logic [7:0] reg_read(input ihp_dstate_t s, input logic [2:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADR_DLOW:  v = s.data[7:0];
            ADR_DMID:  v = s.data[15:8];
            ADR_DHIGH: v = {2'b00, s.data[WORD_W-1:16]};
            ADR_CHEN:  begin
                v[CH_EN_A] = s.en[0];
                v[CH_ST_A] = s.act[0];
                v[CH_EN_B] = s.en[1];
                v[CH_ST_B] = s.act[1];
            end
            ADR_PSYNC: begin
                v[PS_PIN]   = s.ps_pin;
                v[PS_EDGE]  = s.ps_edge;
                v[PS_FIRST] = s.ps_first;
            end
            ADR_SSYNC: v[SS_BLK_HI:SS_BLK_LO] = s.ss_blk;
            ADR_IALOW: v = s.ialow;
            ADR_ACC:   v = s.acc;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sync sources

    assign div_en  = (q.div == 8'(DIV - 1));
    assign pin_evt = q.ps_edge ? (q.sync_s && !q.sync_d) : q.sync_s;
    assign soft_evt = q.hold_run && div_en && (q.hold <= HOLD_W'(1));
    assign sync_evt = q.ps_pin ? pin_evt : soft_evt;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_q        = q;
        next_q.int_wr = 1'b0;
        next_q.int_rd = 1'b0;
        next_q.blk    = 3'b000;
        next_q.sync_m = i_sync_pin;
        next_q.sync_s = q.sync_m;
        next_q.sync_d = q.sync_s;
        next_q.div    = div_en ? 8'h00 : q.div + 8'h01;

        if (q.hold_run && div_en) begin
            if (q.hold <= HOLD_W'(1)) begin
                next_q.hold_run = 1'b0;
            end else begin
                next_q.hold = q.hold - HOLD_W'(1);
            end
        end

        if (sync_evt && !(q.ps_first && |q.act)) begin
            next_q.act = q.act | q.en;
            next_q.blk = q.ss_blk;
        end

        unique case (q.st)
            ST_IDLE: begin
                if (strobe) begin
                    next_q.st       = ST_BUSY;
                    next_q.rd       = rd_req;
                    next_q.sel      = bus.addr;
                    next_q.wait_int = 1'b0;
                    next_q.drv      = 1'b1;
                    next_q.dout     = reg_read(q, bus.addr);
                    if (bus.addr == ADR_DLOW) begin
                        next_q.drv = sel_me;
                        if (sel_me) begin
                            next_q.wait_int = 1'b1;
                            next_q.int_addr = {q.acc[1:0], q.ialow};
                            if (rd_req) begin
                                next_q.int_rd = 1'b1;
                            end else begin
                                next_q.data[7:0] = bus.d_bus;
                                next_q.int_wdata = {q.data[WORD_W-1:8], bus.d_bus};
                                next_q.int_wr    = 1'b1;
                            end
                        end
                    end else if (!rd_req) begin
                        unique case (bus.addr)
                            ADR_DMID:  next_q.data[15:8] = bus.d_bus;
                            ADR_DHIGH: next_q.data[WORD_W-1:16] = bus.d_bus[HIGH_W-1:0];
                            ADR_CHEN:  begin
                                next_q.en = {bus.d_bus[CH_EN_B], bus.d_bus[CH_EN_A]};
                            end
                            ADR_PSYNC: begin
                                next_q.ps_pin   = bus.d_bus[PS_PIN];
                                next_q.ps_edge  = bus.d_bus[PS_EDGE];
                                next_q.ps_first = bus.d_bus[PS_FIRST];
                            end
                            ADR_SSYNC: begin
                                next_q.ss_blk = bus.d_bus[SS_BLK_HI:SS_BLK_LO];
                                if (bus.d_bus[SS_SOFT]) begin
                                    next_q.hold     = i_holdoff;
                                    next_q.hold_run = 1'b1;
                                end
                            end
                            ADR_IALOW: next_q.ialow = bus.d_bus;
                            ADR_ACC:   begin
                                next_q.acc = bus.d_bus;
                                next_q.acc[ACC_RSV] = 1'b0;
                            end
                            default:   next_q.acc = q.acc;
                        endcase
                    end
                end
            end
            ST_BUSY: begin
                if (!q.wait_int || i_int_done) begin
                    next_q.st = ST_DONE;
                    if (q.wait_int) begin
                        if (q.rd) begin
                            next_q.data = i_int_rdata;
                            next_q.dout = i_int_rdata[7:0];
                        end
                        if (q.acc[ACC_AINC]) begin
                            next_q.ialow = q.ialow + 8'h01;
                        end
                    end
                end
            end
            ST_DONE: begin
                if (!strobe) begin
                    next_q.st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q    <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.dev_d    = q.dout;
    assign bus.dev_oe_n = !(q.st == ST_DONE && q.rd && q.drv);
    assign bus.ack      = (bus.mode == MODE_DS) ? (q.st != ST_DONE)
                                                : (q.st != ST_BUSY);

    assign o_int_wr      = q.int_wr;
    assign o_int_rd      = q.int_rd;
    assign o_int_addr    = q.int_addr;
    assign o_int_wdata   = q.int_wdata;
    assign o_chan_active = q.act;
    assign o_blk_sync    = q.blk;

endmodule
`default_nettype wire

// ### hdl/ihp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ihp_host
    import ihp_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // bus style
    input  wire logic        i_mode,
    // user request
    input  wire logic        i_req,
    input  wire logic        i_req_wr,
    input  wire logic [2:0]  i_req_addr,
    input  wire logic [7:0]  i_req_wdata,
    output logic             o_req_ready,
    output logic             o_done,
    output logic [7:0]       o_rdata,
    // device bus
    ihp_if.host              bus
);

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STRB, H_WAIT, H_REL} ihp_hst_t;

    typedef struct packed {
        ihp_hst_t   st;
        logic       wr;
        logic       cs_n;
        logic       strb;
        logic [2:0] addr;
        logic [7:0] d;
        logic       oe_n;
        logic       seen_lo;
        logic [7:0] rdata;
        logic       done;
    } ihp_hstate_t;

    ihp_hstate_t q;
    ihp_hstate_t next_q;

    always_comb begin
        next_q      = q;
        next_q.done = 1'b0;
        unique case (q.st)
            H_IDLE: begin
                if (i_req) begin
                    next_q.st   = H_SETUP;
                    next_q.cs_n = 1'b0;
                    next_q.wr   = i_req_wr;
                    next_q.addr = i_req_addr;
                    next_q.d    = i_req_wdata;
                    if (i_req_addr == ADR_ACC) begin
                        next_q.d = i_req_wdata & ACC_HOST_MASK;
                    end
                    next_q.oe_n = !i_req_wr;
                end
            end
            H_SETUP: begin
                next_q.st      = H_STRB;
                next_q.strb    = 1'b1;
                next_q.seen_lo = 1'b0;
            end
            H_STRB: begin
                next_q.st = H_WAIT;
            end
            H_WAIT: begin
                if (!bus.ack) begin
                    next_q.seen_lo = 1'b1;
                end
                if ((i_mode == MODE_DS) ? !bus.ack : (q.seen_lo && bus.ack)) begin
                    next_q.st    = H_REL;
                    next_q.strb  = 1'b0;
                    next_q.rdata = q.wr ? q.rdata : bus.d_bus;
                end
            end
            H_REL: begin
                next_q.oe_n = 1'b1;
                if (i_mode != MODE_DS || bus.ack) begin
                    next_q.st   = H_IDLE;
                    next_q.done = 1'b1;
                    next_q.cs_n = !i_req;
                end
            end
            default: next_q.st = H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q      <= '0;
            q.st   <= H_IDLE;
            q.cs_n <= 1'b1;
            q.oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // pin meaning per bus style
    assign bus.mode      = i_mode;
    assign bus.cs_n      = q.cs_n;
    assign bus.addr      = q.addr;
    assign bus.host_d    = q.d;
    assign bus.host_oe_n = q.oe_n;
    assign bus.rd_ds_n   = (i_mode == MODE_DS) ? !q.strb : !(q.strb && !q.wr);
    assign bus.wr_rw     = (i_mode == MODE_DS) ? !q.wr : !(q.strb && q.wr);

    assign o_req_ready = (q.st == H_IDLE);
    assign o_done      = q.done;
    assign o_rdata     = q.rdata;

endmodule
`default_nettype wire

// ### test/ihp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ihp_sva
    import ihp_pkg::*;
(
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    // bus
    input wire logic       mode,
    input wire logic       cs_n,
    input wire logic       rd_ds_n,
    input wire logic       wr_rw,
    input wire logic [2:0] addr,
    input wire logic [7:0] host_d,
    input wire logic       host_oe_n,
    input wire logic [7:0] dev_d,
    input wire logic       dev_oe_n,
    input wire logic       ack
);
    wire sep = !cs_n && (!rd_ds_n || !wr_rw) && mode == MODE_SEP;
    wire ds  = !cs_n && !rd_ds_n && mode == MODE_DS;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_sep_go;
        $rose(sep) && ack;
    endsequence
    sequence s_ds_go;
        $rose(ds) && ack ##1 ack;
    endsequence
    chk_ready_drop: assert property (s_sep_go |=> !ack)
        else $error("ready not lowered at access start");
    chk_ready_back: assert property (sep && !ack |-> ##[1:20] ack)
        else $error("ready not released");
    chk_ack_done: assert property (s_ds_go |-> ##[1:20] !ack)
        else $error("acknowledge missing");
    chk_ack_hold: assert property (mode == MODE_DS && !ack && ds |=> !ack)
        else $error("acknowledge dropped under strobe");
    chk_ack_release: assert property (mode == MODE_DS && !ack && !ds |=> ack)
        else $error("acknowledge not returned high");
    chk_drive_read: assert property ($fell(dev_oe_n) |-> !cs_n && (mode ? wr_rw : !rd_ds_n))
        else $error("device drives outside a read");
    chk_no_clash: assert property (dev_oe_n || host_oe_n)
        else $error("both ends drive the bus");
    chk_high_six: assert property (!dev_oe_n && addr == ADR_DHIGH |-> dev_d[7:6] == 2'h0)
        else $error("high data bits not zero");
    chk_rsv_zero: assert property (!dev_oe_n |-> !(addr == ADR_CHEN && dev_d[7:4] != 4'h0)
        && !(addr == ADR_PSYNC && (dev_d & 8'hce) != 8'h00)
        && !(addr == ADR_SSYNC && (dev_d & 8'h8f) != 8'h00))
        else $error("reserved bits read nonzero");
    chk_acc_mask: assert property (!host_oe_n && !cs_n && addr == ADR_ACC
        |-> (host_d & ~ACC_HOST_MASK) == 8'h00)
        else $error("control write sets fixed-zero bits");
    chk_host_release: assert property (sep && $rose(ack) |-> ##[1:2] !sep)
        else $error("strobe held after completion");
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ihp_pkg::*;
    logic clk = 0, rst_n = 0, mode = 0, req = 0, req_wr = 0, sync_pin = 0, int_done = 0;
    logic [2:0] req_addr = 0, blk, blk_seen = 0;
    logic [7:0] req_wd = 0, rdata;
    logic [1:0] device_select_identifier = 0, act;
    logic [15:0] holdoff = 16'h000c;
    logic [21:0] int_rdata = 0, int_wd, exp_wd;
    logic [9:0] int_addr, exp_addr, rd_addr;
    logic ready, done, int_wr, int_rd;
    logic [8:0] note, q[$];
    logic [21:0] mem [1024];
    logic [23:0] wd [4];
    logic [3:0] ins;
    logic sel;
    int num_errors = 0, n_compared = 0, n_wr = 0, cnt = 0, nw, n_blk = 0, nb;
    always #2.5 clk = ~clk;
    ihp_if u_ihp_if();
    ihp_device #(.DIV(2)) u_ihp_device(.i_clk(clk), .i_rst_n(rst_n), .bus(u_ihp_if.dev),
        .i_device_select_identifier(device_select_identifier), .i_sync_pin(sync_pin), .i_holdoff(holdoff), .o_int_wr(int_wr),
        .o_int_rd(int_rd), .o_int_addr(int_addr), .o_int_wdata(int_wd),
        .i_int_rdata(int_rdata), .i_int_done(int_done), .o_chan_active(act), .o_blk_sync(blk));
    ihp_host u_ihp_host(.i_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_req(req),
        .i_req_wr(req_wr), .i_req_addr(req_addr), .i_req_wdata(req_wd), .o_req_ready(ready),
        .o_done(done), .o_rdata(rdata), .bus(u_ihp_if.host));
    ihp_sva u_ihp_sva(.i_clk(clk), .i_rst_n(rst_n), .mode(u_ihp_if.mode), .cs_n(u_ihp_if.cs_n),
        .rd_ds_n(u_ihp_if.rd_ds_n), .wr_rw(u_ihp_if.wr_rw), .addr(u_ihp_if.addr),
        .host_d(u_ihp_if.host_d), .host_oe_n(u_ihp_if.host_oe_n), .dev_d(u_ihp_if.dev_d),
        .dev_oe_n(u_ihp_if.dev_oe_n), .ack(u_ihp_if.ack));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [21:0] seen, input logic [21:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test();
        $display("errors %0d compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one host access; read results are judged by the monitor
    task acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
        int i;
        i = 0;
        @(negedge clk);
        while (ready !== 1'b1 && i < 100) begin
            @(negedge clk);
            i++;
        end
        req = 1;
        req_wr = w;
        req_addr = a;
        req_wd = d;
        q.push_back({!w, e});
        @(negedge clk);
        req = 0;
        while (done !== 1'b1 && i < 200) begin
            @(negedge clk);
            i++;
        end
        if (i >= 200) begin
            num_errors++;
            end_of_test();
        end
    endtask
    task wait_act(input logic [1:0] e);
        int i;
        i = 0;
        while (act !== e && i < 200) begin
            @(negedge clk);
            i++;
        end
        check("channel active", 22'(act), 22'(e));
        if (i >= 200) end_of_test();
    endtask
    task pulse();
        sync_pin = 1;
        @(negedge clk);
        sync_pin = 0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // sampled away from the launching edge
    always @(negedge clk) begin
        if (done === 1'b1 && q.size() > 0) begin
            note = q.pop_front();
            if (note[8]) check("read data", 22'(rdata), 22'(note[7:0]));
        end
        if (blk !== 3'h0) begin
            blk_seen <= blk_seen | blk;
            n_blk++;
        end
    end
    // internal register side, random latency
    always @(negedge clk) begin
        int_done <= 1'b0;
        if (int_wr === 1'b1) begin
            n_wr++;
            mem[int_addr] = int_wd;
            check("write addr", 22'(int_addr), 22'(exp_addr));
            check("write word", int_wd, exp_wd);
            cnt = $urandom_range(2, 5);
        end
        if (int_rd === 1'b1) begin
            rd_addr = int_addr;
            check("read addr", 22'(int_addr), 22'(exp_addr));
            cnt = $urandom_range(2, 5);
        end
        if (cnt > 0) begin
            cnt--;
            if (cnt == 0) begin
                int_done <= 1'b1;
                int_rdata <= mem[rd_addr];
            end
        end
    end
    initial begin
        void'($urandom(4));
        device_select_identifier = 2'($urandom_range(0, 3));
        repeat (5) @(negedge clk);
        rst_n = 1;
        for (int r = 3; r < 8; r++) acc(0, 3'(r), 8'h00, 8'h00);
        acc(1, ADR_CHEN, 8'hff, 8'h00);
        acc(0, ADR_CHEN, 8'h00, 8'h05);
        acc(1, ADR_PSYNC, 8'hff, 8'h00);
        acc(0, ADR_PSYNC, 8'h00, 8'h31);
        acc(1, ADR_SSYNC, 8'hfe, 8'h00);
        acc(0, ADR_SSYNC, 8'h00, 8'h70);
        acc(1, ADR_ACC, 8'hff, 8'h00);
        acc(0, ADR_ACC, 8'h00, 8'hbc);
        for (int r = 3; r < 6; r++) acc(1, 3'(r), 8'h00, 8'h00);
        for (int m = 0; m < 2; m++) begin
            mode = m[0];
            acc(1, ADR_ACC, 8'h80, 8'h00);
            acc(1, ADR_IALOW, 8'hfe, 8'h00);
            for (int k = 0; k < 4; k++) begin
                wd[k] = 24'($urandom);
                acc(1, ADR_DHIGH, wd[k][23:16], 8'h00);
                acc(1, ADR_DMID, wd[k][15:8], 8'h00);
                exp_addr = {2'h0, 8'hfe + 8'(k)};
                exp_wd = wd[k][21:0];
                acc(1, ADR_DLOW, wd[k][7:0], 8'h00);
            end
            acc(1, ADR_IALOW, 8'hfe, 8'h00);
            for (int k = 0; k < 4; k++) begin
                exp_addr = {2'h0, 8'hfe + 8'(k)};
                acc(0, ADR_DLOW, 8'h00, wd[k][7:0]);
                acc(0, ADR_DMID, 8'h00, wd[k][15:8]);
                acc(0, ADR_DHIGH, 8'h00, {2'h0, wd[k][21:16]});
            end
        end
        acc(1, ADR_IALOW, 8'h40, 8'h00);
        exp_addr = 10'h040;
        exp_wd = {wd[3][21:8], 8'h5a};
        for (int c = 0; c < 16; c++) begin
            ins = 4'(c);
            acc(1, ADR_ACC, {2'h0, ins, 2'h0}, 8'h00);
            nw = n_wr;
            acc(1, ADR_DLOW, 8'h5a, 8'h00);
            sel = !ins[3] || (ins[2] ? ins[1:0] == device_select_identifier : !ins[1] && ins[0] == device_select_identifier[0]);
            check("chip selected", 22'(n_wr - nw), 22'(sel));
        end
        acc(1, ADR_CHEN, 8'h05, 8'h00);
        acc(1, ADR_SSYNC, 8'h71, 8'h00);
        check("active early", 22'(act), 22'h0);
        wait_act(2'h3);
        // block pulse is recorded at the same negedge that sees act
        @(negedge clk);
        check("block syncs", 22'(blk_seen), 22'h7);
        acc(0, ADR_CHEN, 8'h00, 8'h0f);
        // let the monitor take the last done before reset clears it
        @(negedge clk);
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        check("active after reset", 22'(act), 22'h0);
        acc(1, ADR_CHEN, 8'h01, 8'h00);
        acc(1, ADR_PSYNC, 8'h21, 8'h00);
        pulse();
        wait_act(2'h1);
        acc(1, ADR_CHEN, 8'h05, 8'h00);
        pulse();
        repeat (10) @(negedge clk);
        check("resync ignored", 22'(act), 22'h1);
        // edge mode: a long high level is one event only
        acc(1, ADR_SSYNC, 8'h70, 8'h00);
        acc(1, ADR_PSYNC, 8'h11, 8'h00);
        nb = n_blk;
        sync_pin = 1;
        repeat (6) @(negedge clk);
        sync_pin = 0;
        repeat (4) @(negedge clk);
        check("edge events", 22'(n_blk - nb), 22'h1);
        check("notes left", 22'(q.size()), 22'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
